// *** common/pia_pkg.sv ***
////////////////////////////////////////////////////////////////////////////////
// constants shared by the controller and its priority picker
package pia_pkg;
    localparam int DW = 8;
    localparam int LW = 3;
    // register select values
    localparam logic SEL_COMMAND = 1'b0;
    localparam logic SEL_MASK = 1'b1;
    // first init word field positions
    localparam int BIT_INIT_MARK = 4;
    localparam int BIT_LEVEL_TRIGGER = 3;
    localparam int BIT_CALL_INTERVAL = 2;
    localparam int BIT_SINGLE_DEVICE = 1;
    localparam int BIT_FOURTH_NEEDED = 0;
    // fourth init word field positions
    localparam int BIT_SPECIAL_NESTED = 4;
    localparam int BIT_BUFFERED = 3;
    localparam int BIT_MASTER_SEL = 2;
    localparam int BIT_AUTO_END = 1;
    localparam int BIT_CPU16 = 0;
    // operation word fields beyond the mask word
    localparam int BIT_OP_THIRD = 3;
    localparam int BIT_POLL = 2;
    localparam int BIT_READ_REG = 1;
    localparam int BIT_READ_IN_SERVICE = 0;
    localparam int BIT_SMM_ENABLE = 6;
    localparam int BIT_SMM_VALUE = 5;
    localparam logic [2:0] NONSPEC_END_CODE = 3'h1;
    // fixed bytes and reset values
    localparam logic [DW-1:0] CALL_OPCODE = 8'hCD;
    localparam logic [LW-1:0] SPURIOUS_LEVEL = 3'h7;
    localparam logic [DW-1:0] SLAVE_ID_RESET = 8'h07;
    localparam logic [DW-1:0] MASK_RESET = 8'h00;
    localparam logic [DW-1:0] EDGE_RESET = 8'hFF;
    localparam logic [DW-1:0] WORD_FOUR_ZERO = 8'h00;
    // acknowledge pulse counts per processor type
    localparam logic [1:0] LAST_PULSE_8BIT = 2'h3;
    localparam logic [1:0] LAST_PULSE_16BIT = 2'h2;
    // initialization sequencer states
    typedef enum logic [1:0] {
        ST_READY,
        ST_WAIT2,
        ST_WAIT3,
        ST_WAIT4
    } pia_init_st_t;
endpackage

// *** design/pia_pick.sv ***
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// finds the lowest set bit, which is the highest priority level
module pia_pick (
    input wire logic [pia_pkg::DW-1:0] vec,
    output logic any,
    output logic [pia_pkg::LW-1:0] lvl
);
    import pia_pkg::*;

    logic [DW:0] seen;
    logic [DW-1:0] first;

    assign seen[0] = 1'b0;
    // one-hot of the first set bit, chained per bit
    for (genvar i = 0; i < DW; i++) begin : g_bit
        assign seen[i+1] = seen[i] | vec[i];
        assign first[i] = vec[i] & ~seen[i];
    end

    assign any = seen[DW];

    // encode the one-hot position
    always_comb begin
        lvl = '0;
        for (int i = 0; i < DW; i++) begin
            if (first[i]) begin
                lvl = LW'(i);
            end
        end
    end
endmodule

// *** design/pia_ctrl.sv ***
`timescale 1ns/1ps
// Operation
// - read with chip select drives request, in-service, mask latch or level
// - first acknowledge sets in-service bit, clears that request bit
// - 8-bit mode: master or lone device drives call opcode on first acknowledge
// - 8-bit mode: low address byte second, high byte third
// - low byte layout depends on call interval 4 or 8
// - call interval bit 1 means interval 4, 0 means 8
// - third acknowledge drives the second init word as high byte
// - 8-bit auto end clears in-service after third pulse
// - 16-bit first pulse: bus undriven, freeze state, cascade code after
// - 16-bit second pulse drives vector base bits and level
// - 16-bit auto end clears in-service after second pulse
// - no request at first acknowledge answers as level 7
// - master puts slave id on cascade lines; matching slave answers
// - command write with bit 4 set restarts initialization
// - first init word resets edges, mask, slave id, special mask, read select
// - no fourth word needed zeroes all fourth word functions
// - init takes 2 to 4 writes; third skipped when single
// - level trigger bit makes a high level a request
// - third word: master slave bits, or slave id compared on cascade
// - buffered: pin is buffer enable and master bit sets role
// - processor type bit picks three or two pulse acknowledge
// - special nested and auto end options come from fourth word
// - mask writes at any time after initialization load the mask latch
// - a set mask bit inhibits its request input
// - fully nested, level 0 highest; in-service blocks same or lower
// - non-specific end command clears highest set in-service bit
module pia_ctrl (
    input wire logic CLK,
    input wire logic SRST,
    input wire logic CS_N,
    input wire logic RD_N,
    input wire logic WR_N,
    input wire logic REGISTER_SELECT,
    input wire logic INT_ACK_STROBE_N,
    input wire logic [pia_pkg::DW-1:0] DATA_IN,
    output logic [pia_pkg::DW-1:0] DATA_OUT,
    output logic DATA_OE,
    input wire logic [pia_pkg::DW-1:0] REQUEST_INPUTS,
    output logic INT_REQUEST,
    input wire logic [pia_pkg::LW-1:0] CASCADE_ID_LINES_I,
    output logic [pia_pkg::LW-1:0] CASCADE_ID_LINES_O,
    output logic CASCADE_ID_LINES_OE,
    input wire logic SLAVE_PROGRAM_PIN_I,
    output logic SLAVE_PROGRAM_PIN_O,
    output logic SLAVE_PROGRAM_PIN_OE
);
    import pia_pkg::*;

    typedef struct packed {
        logic wr_p;
        logic rd_p;
        logic ak_p;
        logic sel_w;
        logic [DW-1:0] wdat;
        pia_init_st_t st;
        logic done;
        logic [DW-1:0] init_word_one;
        logic [DW-1:0] init_word_two;
        logic [DW-1:0] init_word_three;
        logic [DW-1:0] init_word_four;
        logic [DW-1:0] mask_latch;
        logic [DW-1:0] request_latch;
        logic [DW-1:0] in_service_latch;
        logic [DW-1:0] prev_in;
        logic smm;
        logic read_in_service;
        logic poll;
        logic poll_read;
        logic [1:0] cnt;
        logic [LW-1:0] lvl;
        logic hit;
        logic [LW-1:0] cascade_id;
        logic cascade_on;
        logic [DW-1:0] dout;
        logic doe;
    } pia_state_t;

    pia_state_t s_r;
    pia_state_t s_nxt;

    logic wr_act;
    logic rd_act;
    logic ak_act;
    logic wr_rise;
    logic rd_fall;
    logic ak_fall;
    logic ak_rise;
    logic master;
    logic cascaded;
    logic upm_mode;
    logic level_mode;
    logic auto_end;
    logic supply_call;
    logic supply_vec;
    logic [1:0] last_pulse;
    logic [DW-1:0] pending;
    logic [DW-1:0] blocking;
    logic p_any;
    logic [LW-1:0] p_lvl;
    logic b_any;
    logic [LW-1:0] b_lvl;
    logic nest_ok;
    logic grant;

    ////////////////////////////////////////////////////////////////////////////
    // strobe levels and edges; inputs are already in the clock domain
    assign wr_act = !CS_N && !WR_N;
    assign rd_act = !CS_N && !RD_N;
    assign ak_act = !INT_ACK_STROBE_N;
    // each edge is seen in exactly one cycle against the stored level
    assign wr_rise = s_r.wr_p && !wr_act;
    assign rd_fall = rd_act && !s_r.rd_p;
    assign ak_fall = ak_act && !s_r.ak_p;
    assign ak_rise = !ak_act && s_r.ak_p;

    // role and mode decode from the stored init words
    assign master = s_r.init_word_four[BIT_BUFFERED] ? s_r.init_word_four[BIT_MASTER_SEL]
                                                     : SLAVE_PROGRAM_PIN_I;
    assign cascaded = !s_r.init_word_one[BIT_SINGLE_DEVICE];
    assign upm_mode = s_r.init_word_four[BIT_CPU16];
    assign level_mode = s_r.init_word_one[BIT_LEVEL_TRIGGER];
    assign auto_end = s_r.init_word_four[BIT_AUTO_END];
    assign last_pulse = upm_mode ? LAST_PULSE_16BIT : LAST_PULSE_8BIT;
    // a slave never sends the call opcode; the master or a lone device does
    assign supply_call = !cascaded || master;

    ////////////////////////////////////////////////////////////////////////////
    // priority resolution over unmasked requests and blocking in-service bits
    assign pending = s_r.request_latch & ~s_r.mask_latch;
    // in special mask mode a masked level no longer blocks anything
    assign blocking = s_r.smm ? (s_r.in_service_latch & ~s_r.mask_latch)
                              : s_r.in_service_latch;

    pia_pick u_pick_req (
        .vec(pending),
        .any(p_any),
        .lvl(p_lvl)
    );

    pia_pick u_pick_isv (
        .vec(blocking),
        .any(b_any),
        .lvl(b_lvl)
    );

    // special nesting lets a cascaded slave level interrupt its own level
    assign nest_ok = s_r.init_word_four[BIT_SPECIAL_NESTED] && master && cascaded
                     && s_r.init_word_three[p_lvl] && (p_lvl == b_lvl);
    assign grant = p_any && (!b_any || (p_lvl < b_lvl) || nest_ok);

    ////////////////////////////////////////////////////////////////////////////
    // next state
    always_comb begin
        s_nxt = s_r;
        s_nxt.wr_p = wr_act;
        s_nxt.rd_p = rd_act;
        s_nxt.ak_p = ak_act;
        supply_vec = 1'b0;
        // hold the write data while the strobe is low, use it at the rise
        if (wr_act) begin
            s_nxt.sel_w = REGISTER_SELECT;
            s_nxt.wdat = DATA_IN;
        end
        // request latch: level follows input, edge needs a fresh rise
        if (level_mode) begin
            s_nxt.request_latch = REQUEST_INPUTS;
        end else begin
            s_nxt.request_latch = (s_r.request_latch | (REQUEST_INPUTS & ~s_r.prev_in))
                                  & REQUEST_INPUTS;
        end
        s_nxt.prev_in = REQUEST_INPUTS;
        // command writes, before the acknowledge so that a set wins
        if (wr_rise) begin
            if ((s_r.sel_w == SEL_COMMAND) && s_r.wdat[BIT_INIT_MARK]) begin
                s_nxt.init_word_one = s_r.wdat;
                s_nxt.st = ST_WAIT2;
                s_nxt.done = 1'b0;
                s_nxt.prev_in = EDGE_RESET;
                s_nxt.request_latch = '0;
                s_nxt.in_service_latch = '0;
                s_nxt.mask_latch = MASK_RESET;
                s_nxt.init_word_three = SLAVE_ID_RESET;
                s_nxt.smm = 1'b0;
                s_nxt.read_in_service = 1'b0;
                s_nxt.poll = 1'b0;
                s_nxt.cnt = 2'h0;
                s_nxt.cascade_on = 1'b0;
                if (!s_r.wdat[BIT_FOURTH_NEEDED]) begin
                    s_nxt.init_word_four = WORD_FOUR_ZERO;
                end
            end else begin
                case (s_r.st)
                    ST_WAIT2: begin
                        s_nxt.init_word_two = s_r.wdat;
                        if (cascaded) begin
                            s_nxt.st = ST_WAIT3;
                        end else if (s_r.init_word_one[BIT_FOURTH_NEEDED]) begin
                            s_nxt.st = ST_WAIT4;
                        end else begin
                            s_nxt.st = ST_READY;
                            s_nxt.done = 1'b1;
                        end
                    end
                    ST_WAIT3: begin
                        s_nxt.init_word_three = s_r.wdat;
                        if (s_r.init_word_one[BIT_FOURTH_NEEDED]) begin
                            s_nxt.st = ST_WAIT4;
                        end else begin
                            s_nxt.st = ST_READY;
                            s_nxt.done = 1'b1;
                        end
                    end
                    ST_WAIT4: begin
                        s_nxt.init_word_four = s_r.wdat;
                        s_nxt.st = ST_READY;
                        s_nxt.done = 1'b1;
                    end
                    ST_READY: begin
                        if (!s_r.done) begin
                            s_nxt.st = ST_READY;
                        end else if (s_r.sel_w == SEL_MASK) begin
                            s_nxt.mask_latch = s_r.wdat;
                        end else if (!s_r.wdat[BIT_OP_THIRD]) begin
                            if ((s_r.wdat[7:5] == NONSPEC_END_CODE) && b_any) begin
                                s_nxt.in_service_latch[b_lvl] = 1'b0;
                            end
                        end else begin
                            s_nxt.poll = s_r.wdat[BIT_POLL];
                            if (s_r.wdat[BIT_READ_REG]) begin
                                s_nxt.read_in_service = s_r.wdat[BIT_READ_IN_SERVICE];
                            end
                            if (s_r.wdat[BIT_SMM_ENABLE]) begin
                                s_nxt.smm = s_r.wdat[BIT_SMM_VALUE];
                            end
                        end
                    end
                    default: begin
                        s_nxt.st = ST_READY;
                    end
                endcase
            end
        end
        // start of an acknowledge pulse
        if (ak_fall && s_r.done) begin
            s_nxt.cnt = s_r.cnt + 2'h1;
            if (s_r.cnt == 2'h0) begin
                // state is frozen here; a vanished request answers as level 7
                s_nxt.hit = grant;
                s_nxt.lvl = grant ? p_lvl : SPURIOUS_LEVEL;
                if (grant) begin
                    s_nxt.in_service_latch[p_lvl] = 1'b1;
                    s_nxt.request_latch[p_lvl] = 1'b0;
                end
                if (!upm_mode) begin
                    s_nxt.cascade_id = s_nxt.lvl;
                    s_nxt.cascade_on = 1'b1;
                end
            end
        end
        // end of an acknowledge pulse
        if (ak_rise && (s_r.cnt != 2'h0)) begin
            if ((s_r.cnt == 2'h1) && upm_mode) begin
                s_nxt.cascade_id = s_r.lvl;
                s_nxt.cascade_on = 1'b1;
            end
            if (s_r.cnt == last_pulse) begin
                s_nxt.cnt = 2'h0;
                s_nxt.cascade_on = 1'b0;
                if (auto_end && s_r.hit) begin
                    s_nxt.in_service_latch[s_r.lvl] = 1'b0;
                end
            end
        end
        // poll read acts as an acknowledge and returns the level word
        if (rd_fall && s_r.poll && s_r.done && (REGISTER_SELECT == SEL_COMMAND)) begin
            s_nxt.poll = 1'b0;
            s_nxt.poll_read = 1'b1;
            s_nxt.dout = {grant, 4'h0, p_lvl};
            if (grant) begin
                s_nxt.in_service_latch[p_lvl] = 1'b1;
                s_nxt.request_latch[p_lvl] = 1'b0;
            end
        end else if (!rd_act) begin
            s_nxt.poll_read = 1'b0;
        end
        // data bus: acknowledge bytes, status reads, or released
        s_nxt.doe = 1'b0;
        if (ak_act && s_r.done && (s_nxt.cnt != 2'h0)) begin
            // master answers unless the level belongs to a slave; slave on id match
            if (!cascaded) begin
                supply_vec = 1'b1;
            end else if (master) begin
                supply_vec = !s_r.init_word_three[s_nxt.lvl];
            end else begin
                supply_vec = (CASCADE_ID_LINES_I == s_r.init_word_three[LW-1:0]);
            end
            case (s_nxt.cnt)
                2'h1: begin
                    // 16-bit mode leaves the bus released on the first pulse
                    s_nxt.doe = !upm_mode && supply_call;
                    s_nxt.dout = CALL_OPCODE;
                end
                2'h2: begin
                    s_nxt.doe = supply_vec;
                    if (upm_mode) begin
                        s_nxt.dout = {s_r.init_word_two[7:3], s_nxt.lvl};
                    end else if (s_r.init_word_one[BIT_CALL_INTERVAL]) begin
                        s_nxt.dout = {s_r.init_word_one[7:5], s_nxt.lvl, 2'h0};
                    end else begin
                        s_nxt.dout = {s_r.init_word_one[7:6], s_nxt.lvl, 3'h0};
                    end
                end
                2'h3: begin
                    s_nxt.doe = supply_vec && !upm_mode;
                    s_nxt.dout = s_r.init_word_two;
                end
                default: begin
                    s_nxt.doe = 1'b0;
                end
            endcase
        end else if (rd_act) begin
            s_nxt.doe = 1'b1;
            if (s_nxt.poll_read) begin
                s_nxt.doe = 1'b1;
            end else if (REGISTER_SELECT == SEL_MASK) begin
                s_nxt.dout = s_r.mask_latch;
            end else if (s_r.read_in_service) begin
                s_nxt.dout = s_r.in_service_latch;
            end else begin
                s_nxt.dout = s_r.request_latch;
            end
        end
    end

    // all state in one register; reset leaves the device uninitialized
    always_ff @(posedge CLK) begin
        if (SRST) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs
    assign DATA_OUT = s_r.dout;
    assign DATA_OE = s_r.doe;
    assign INT_REQUEST = s_r.done && grant;
    // cascade lines are outputs only on a master of a cascade
    assign CASCADE_ID_LINES_OE = master && cascaded;
    assign CASCADE_ID_LINES_O = s_r.cascade_on ? s_r.cascade_id : '0;
    // buffered mode: low while the data bus is driven, to steer transceivers
    assign SLAVE_PROGRAM_PIN_O = !s_r.doe;
    assign SLAVE_PROGRAM_PIN_OE = s_r.init_word_four[BIT_BUFFERED];

    ////////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (SRST);

    sequence q_first_ack;
        ak_fall && s_r.done && (s_r.cnt == 2'h0);
    endsequence

    sequence q_init_write;
        wr_rise && (s_r.sel_w == SEL_COMMAND) && s_r.wdat[BIT_INIT_MARK];
    endsequence

    a_call_opcode: assert property (
        q_first_ack ##0 (!upm_mode && supply_call) |=> DATA_OE && (DATA_OUT == CALL_OPCODE)
    ) else $error("call opcode not driven on first pulse");

    a_set_in_service: assert property (
        q_first_ack ##0 grant |=> s_r.in_service_latch[$past(p_lvl)]
    ) else $error("in-service bit not set on first pulse");

    a_spurious_level: assert property (
        q_first_ack ##0 !grant |=> (s_r.lvl == SPURIOUS_LEVEL) && !s_r.hit
    ) else $error("empty acknowledge did not answer level 7");

    a_quiet_first16: assert property (
        s_r.done && upm_mode && (s_r.cnt == 2'h1) && $past(!rd_act) |-> !DATA_OE
    ) else $error("bus driven on first 16-bit pulse");

    a_vector_byte16: assert property (
        upm_mode && (s_r.cnt == 2'h2) && $past(ak_act) && DATA_OE
        |-> DATA_OUT == {s_r.init_word_two[7:3], s_r.lvl}
    ) else $error("16-bit vector byte wrong");

    a_auto_clear: assert property (
        ak_rise && (s_r.cnt == last_pulse) && auto_end && s_r.hit
        |=> !s_r.in_service_latch[$past(s_r.lvl)] && (s_r.cnt == 2'h0)
    ) else $error("auto end did not clear in-service bit");

    a_mask_load: assert property (
        wr_rise && (s_r.sel_w == SEL_MASK) && s_r.done |=> s_r.mask_latch == $past(s_r.wdat)
    ) else $error("mask write not loaded");

    a_init_defaults: assert property (
        q_init_write |=> (s_r.mask_latch == MASK_RESET) && !s_r.smm && !s_r.read_in_service
                         && (s_r.init_word_three == SLAVE_ID_RESET) && (s_r.st == ST_WAIT2)
    ) else $error("init word one defaults not applied");

    a_fourth_zero: assert property (
        q_init_write ##0 !s_r.wdat[BIT_FOURTH_NEEDED] |=> s_r.init_word_four == WORD_FOUR_ZERO
    ) else $error("fourth word functions not zeroed");

    a_masked_quiet: assert property (
        (s_r.mask_latch == EDGE_RESET) |-> !INT_REQUEST
    ) else $error("request raised with all inputs masked");
endmodule

// *** dv/pia_host.sv ***
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// host processor model: register writes, reads and acknowledge pulses
module pia_host (
    input wire logic clk,
    output logic cs_n,
    output logic rd_n,
    output logic wr_n,
    output logic reg_sel,
    output logic ack_n,
    output logic [pia_pkg::DW-1:0] data_in,
    input wire logic [pia_pkg::DW-1:0] data_out,
    input wire logic data_oe
);
    import pia_pkg::*;

    // idle bus, strobes high
    initial begin
        cs_n = 1'b1;
        rd_n = 1'b1;
        wr_n = 1'b1;
        reg_sel = 1'b0;
        ack_n = 1'b1;
        data_in = 8'h00;
    end
    // one write strobe per byte; data inverted once released so it never lingers
    task automatic wr(input logic sel, input logic [DW-1:0] d);
        @(posedge clk);
        #1 cs_n = 1'b0;
        wr_n = 1'b0;
        reg_sel = sel;
        data_in = d;
        @(posedge clk);
        #1 wr_n = 1'b1;
        cs_n = 1'b1;
        data_in = ~d;
        repeat (2) @(posedge clk);
    endtask
    // status read, sampled while the strobe is still low
    task automatic rd(input logic sel, output logic [DW-1:0] d);
        @(posedge clk);
        #1 cs_n = 1'b0;
        rd_n = 1'b0;
        reg_sel = sel;
        repeat (2) @(posedge clk);
        #1 d = data_out;
        rd_n = 1'b1;
        cs_n = 1'b1;
        repeat (2) @(posedge clk);
    endtask
    // one acknowledge pulse; the bench issues exactly three or two per sequence
    task automatic ack(output logic [DW-1:0] d, output logic oe);
        @(posedge clk);
        #1 ack_n = 1'b0;
        repeat (3) @(posedge clk);
        #1 d = data_out;
        oe = data_oe;
        ack_n = 1'b1;
        repeat (3) @(posedge clk);
    endtask
endmodule

// *** dv/prog_interrupt_ack_and_init_bench.sv ***
`timescale 1ns/1ps
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin n_mismatch++; \
    $display("MISMATCH %s expected %h seen %h", nm, e, g); end end
////////////////////////////////////////////////////////////////////////////////
module prog_interrupt_ack_and_init_bench;
    import pia_pkg::*;
    logic clk, srst, cs_n, rd_n, wr_n, sel, ack_n, oe, irq;
    logic [DW-1:0] din, dout, req, d, w1, w2;
    logic [LW-1:0] lvl;
    int n_mismatch = 0;
    int check_count = 0;
    int cyc = 0;
    pia_host h (.clk(clk), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n), .reg_sel(sel),
        .ack_n(ack_n), .data_in(din), .data_out(dout), .data_oe(oe));
    logic doe, aoe, spoe;
    logic [LW-1:0] cas;
    // cascade input and role pin tied: single master only
    pia_ctrl u_dut (.CLK(clk), .SRST(srst), .CS_N(cs_n), .RD_N(rd_n), .WR_N(wr_n),
        .REGISTER_SELECT(sel), .INT_ACK_STROBE_N(ack_n), .DATA_IN(din), .DATA_OUT(dout),
        .DATA_OE(doe), .REQUEST_INPUTS(req), .INT_REQUEST(irq), .CASCADE_ID_LINES_I(3'h0),
        .CASCADE_ID_LINES_O(cas), .CASCADE_ID_LINES_OE(), .SLAVE_PROGRAM_PIN_I(1'b1),
        .SLAVE_PROGRAM_PIN_O(), .SLAVE_PROGRAM_PIN_OE(spoe));
    assign oe = doe;
    // expected low call byte for interval 4 or 8
    function automatic logic [7:0] exp_low(input logic [7:0] w, input logic [2:0] l);
        return w[BIT_CALL_INTERVAL] ? {w[7:5], l, 2'b00} : {w[7:6], l, 3'b000};
    endfunction
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // hang guard, far above the fewer than one thousand cycles the run needs
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            n_mismatch++;
            print_verdict();
        end
    end
    initial begin
        srst = 1'b1;
        req = 8'h00;
        void'($urandom(82462));
        repeat (4) @(posedge clk);
        #1 srst = 1'b0;
        // three-pulse mode, single, no fourth word, both call intervals
        for (int i = 0; i < 8; i++) begin
            lvl = 3'($urandom_range(0, 7));
            w2 = 8'($urandom);
            w1 = {3'($urandom), 1'b1, 1'b0, i[0], 1'b1, 1'b0};
            #1 req = 8'h00;
            h.wr(SEL_COMMAND, w1);
            // later init words go with select high, so a random bit 4 cannot restart
            h.wr(SEL_MASK, w2);
            h.wr(SEL_MASK, 8'h00);
            #1 req = 8'h01 << lvl;
            repeat (3) @(posedge clk);
            `CHK("int", 1'b1, irq)
            h.rd(SEL_COMMAND, d);
            `CHK("request", 8'h01 << lvl, d)
            h.ack(d, aoe);
            `CHK("call", CALL_OPCODE, d)
            `CHK("call_oe", 1'b1, aoe)
            h.ack(d, aoe);
            `CHK("low", exp_low(w1, lvl), d)
            h.ack(d, aoe);
            `CHK("high", w2, d)
            h.wr(SEL_COMMAND, 8'h0B);
            h.rd(SEL_COMMAND, d);
            `CHK("inservice", 8'h01 << lvl, d)
            `CHK("blocked", 1'b0, irq)
            h.wr(SEL_COMMAND, 8'h20);
            h.rd(SEL_COMMAND, d);
            `CHK("endcmd", 8'h00, d)
            h.wr(SEL_MASK, 8'h01 << lvl);
            #1 req = 8'h00;
            repeat (2) @(posedge clk);
            #1 req = 8'h01 << lvl;
            repeat (3) @(posedge clk);
            `CHK("masked", 1'b0, irq)
            h.rd(SEL_MASK, d);
            `CHK("mask", 8'h01 << lvl, d)
            // every input masked at once
            h.wr(SEL_MASK, 8'hFF);
            `CHK("allmask", 1'b0, irq)
        end
        // two-pulse mode with auto end; last pass has no request at all
        for (int j = 0; j < 6; j++) begin
            lvl = 3'($urandom_range(0, 7));
            w2 = 8'($urandom);
            w1 = {3'($urandom), 1'b1, j[0], 1'b0, 1'b1, 1'b1};
            #1 req = 8'h00;
            h.wr(SEL_COMMAND, w1);
            h.wr(SEL_MASK, w2);
            // buffered master, auto end, two-pulse mode
            h.wr(SEL_MASK, 8'h0F);
            `CHK("buffered", 1'b1, spoe)
            h.wr(SEL_MASK, 8'h00);
            #1 req = (j == 5) ? 8'h00 : 8'h01 << lvl;
            if (j == 5)
                lvl = SPURIOUS_LEVEL;
            repeat (3) @(posedge clk);
            h.ack(d, aoe);
            `CHK("first_oe", 1'b0, aoe)
            `CHK("cascade", lvl, cas)
            h.ack(d, aoe);
            `CHK("vector", {w2[7:3], lvl}, d)
            h.wr(SEL_COMMAND, 8'h0B);
            h.rd(SEL_COMMAND, d);
            `CHK("autoend", 8'h00, d)
            h.wr(SEL_COMMAND, 8'h0A);
            h.rd(SEL_COMMAND, d);
            `CHK("relatch", (j[0] && j != 5) ? 8'h01 << lvl : 8'h00, d)
        end
        print_verdict();
    end
endmodule
